// ==== hdl/cbu_branch_unit.sv ====
// Conditional branch unit: compare-with-zero branches ge, gt and le.
// Assumes decode presents one instruction per cycle, holds it while busy,
// and that issue inputs are synchronous to ref_clk.
// Limitation: equal, not-equal and less-than branches and the prefix word
// itself belong to other units; such words only raise not_branch.
// The prefix upper half must reach this unit along with the branch word.
//
// Contract
// - Greater-or-equal forms branch when operand is at least zero.
// - Greater-than forms branch only when operand is strictly above zero.
// - Less-or-equal forms branch when operand is zero or below.
// - Register form: taken loads PC plus offset register; else PC plus four.
// - Immediate form: taken loads PC plus sign-extended immediate.
// - Instruction position 6 is the delay-slot flag.
// - Flag set: the following instruction completes before the target.
// - Flag clear: following instruction is squashed; target executes next.
// - An untaken conditional branch completes in one cycle.
// - Taken with delay-slot flag set costs two cycles.
// - Taken with delay-slot flag clear costs three cycles.
// - Immediate form correctly predicted completes in one cycle.
// - Immediate form mispredicted costs three cycles.
// - Immediate offset sign-extends from sixteen to thirty-two bits.
// - A preceding immediate prefix supplies the full-width offset instead.
// - Register ge: opcode 100111, flag, condition 0101, zero low bits.
// - Register gt: opcode 100111, condition 0100 after the flag.
// - Register le: opcode 100111, flag, condition 0011.
// - Immediate ge: opcode 101111, flag, condition 0101.
// - Immediate gt: opcode 101111, flag, condition 0100.

`include "cbu_regs.svh"

module cbu_branch_unit (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Instruction from decode
  input  wire cbu_pkg::cbu_issue_t issue,
  // Outcome to the PC and fetch stage
  output cbu_pkg::cbu_result_t     result,
  output logic                     busy,
  output logic                     not_branch
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Condition field to comparison kind, shared by both forms
  // Unknown codes map to none, which the caller turns into not_branch
  function automatic cbu_pkg::cbu_cmp_t cond_kind(
    input logic [3:0] cond,
    input logic       imm_form
  );
    cbu_pkg::cbu_cmp_t kind;
    kind = cbu_pkg::CBU_CMP_NONE;
    if (cond == `CBU_COND_GE) begin
      kind = cbu_pkg::CBU_CMP_GE;
    end else if (cond == `CBU_COND_GT) begin
      kind = cbu_pkg::CBU_CMP_GT;
    end else if (cond == `CBU_COND_LE && !imm_form) begin
      kind = cbu_pkg::CBU_CMP_LE;
    end else if (cond == `CBU_COND_LE && imm_form) begin
      kind = cbu_pkg::CBU_CMP_LE;
    end
    return kind;
  endfunction : cond_kind

  // Signed test of the operand against zero
  function automatic logic cond_met(
    input cbu_pkg::cbu_cmp_t kind,
    input logic [31:0]       value
  );
    logic neg;
    logic zero;
    logic met;
    // Sign bit and a zero test suffice; no subtractor sits in this path
    neg  = value[31];
    zero = (value == 32'h00000000);
    met  = 1'b0;
    case (kind)
      cbu_pkg::CBU_CMP_GE: begin
        met = !neg;
      end
      cbu_pkg::CBU_CMP_GT: begin
        met = !neg && !zero;
      end
      cbu_pkg::CBU_CMP_LE: begin
        met = neg || zero;
      end
      default: begin
        met = 1'b0;
      end
    endcase
    return met;
  endfunction : cond_met

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------

  logic [5:0]        opcode;
  logic              dslot;
  logic [3:0]        cond;
  logic              low_zero;
  logic              is_reg;
  logic              is_imm;
  cbu_pkg::cbu_cmp_t kind;
  logic              is_branch;
  logic              accept;

  // Field extraction
  assign opcode   = issue.instr[`CBU_OPC_HI:`CBU_OPC_LO];
  assign dslot    = issue.instr[`CBU_DSLOT_BIT];
  assign cond     = issue.instr[`CBU_COND_HI:`CBU_COND_LO];
  assign low_zero = (issue.instr[`CBU_LOW_HI:0] == 11'h000);

  // Form select; the register form insists on zero-filled low bits
  assign is_reg = (opcode == `CBU_OPC_REG) && low_zero;
  assign is_imm = (opcode == `CBU_OPC_IMM);
  assign kind   = cond_kind(cond, is_imm);

  // Only the three conditions owned here are claimed
  assign is_branch = (is_reg || is_imm) && (kind != cbu_pkg::CBU_CMP_NONE);

  // ----------------------------------------------------------------
  // Target and outcome
  // ----------------------------------------------------------------

  logic [31:0] imm_offset;
  logic [31:0] offset;
  logic [31:0] target;
  logic [31:0] seq_pc;
  logic        take;
  logic        predicted;
  logic        wrong;
  logic [1:0]  next_cost;

  // Prefix widens the offset; without it the short field sign-extends
  always_comb begin
    if (issue.prefix_valid) begin
      imm_offset = {issue.prefix_hi, issue.instr[`CBU_IMM_HI:0]};
    end else begin
      imm_offset = {{16{issue.instr[`CBU_IMM_HI]}}, issue.instr[`CBU_IMM_HI:0]};
    end
  end

  // Offset source by form
  always_comb begin
    if (is_imm) begin
      offset = imm_offset;
    end else begin
      offset = issue.offset_reg;
    end
  end

  // Adders wrap modulo 2^32, as the PC itself does
  // Both sums are formed every cycle so the choice adds no extra stage
  assign target = issue.program_counter + offset;
  assign seq_pc = issue.program_counter + `CBU_PC_STEP;
  assign take   = cond_met(kind, issue.compare_operand_reg);

  // Prediction only counts for the immediate forms; a guess that arrives
  // with a register form is ignored, since its target comes from a register
  assign predicted = is_imm && issue.predict_valid;
  assign wrong     = predicted && (issue.predict_taken != take);

  // Cost in cycles; prediction overrides the plain taken and untaken costs
  always_comb begin
    if (predicted && !wrong) begin
      next_cost = `CBU_COST_ONE;
    end else if (wrong) begin
      next_cost = `CBU_COST_FULL;
    end else if (!take) begin
      next_cost = `CBU_COST_ONE;
    end else if (dslot) begin
      next_cost = `CBU_COST_SLOT;
    end else begin
      next_cost = `CBU_COST_FULL;
    end
  end

  // ----------------------------------------------------------------
  // Stall sequencer
  // ----------------------------------------------------------------

  cbu_pkg::cbu_state_t state;
  cbu_pkg::cbu_state_t next_state;

  // A new branch is only taken while no penalty is being served
  // Words that arrive while busy are dropped, not queued: decode must hold them
  assign accept = issue.valid && is_branch && (state == cbu_pkg::CBU_IDLE);

  // Each extra cost cycle is one penalty state
  always_comb begin
    next_state = state;
    case (state)
      cbu_pkg::CBU_IDLE: begin
        if (accept && next_cost == `CBU_COST_FULL) begin
          next_state = cbu_pkg::CBU_PEN2;
        end else if (accept && next_cost == `CBU_COST_SLOT) begin
          next_state = cbu_pkg::CBU_PEN1;
        end else begin
          next_state = cbu_pkg::CBU_IDLE;
        end
      end
      cbu_pkg::CBU_PEN2: begin
        next_state = cbu_pkg::CBU_PEN1;
      end
      cbu_pkg::CBU_PEN1: begin
        next_state = cbu_pkg::CBU_IDLE;
      end
      default: begin
        next_state = cbu_pkg::CBU_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= cbu_pkg::CBU_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Busy is registered so decode sees a clean stall
  // It follows next_state, so busy and a non-idle state always agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != cbu_pkg::CBU_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Outcome registers
  // ----------------------------------------------------------------

  // Valid and redirect strobes last one cycle per accepted branch
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result.valid   <= 1'b0;
      result.taken   <= 1'b0;
      result.pc_load <= 1'b0;
    end else begin
      result.valid   <= accept;
      result.taken   <= accept && take;
      result.pc_load <= accept;
    end
  end

  // Next PC holds until the following accepted branch
  // Holding it lets the PC stage pick it up late without a second strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result.next_pc <= `CBU_PC_RESET;
    end else if (accept && take) begin
      result.next_pc <= target;
    end else if (accept) begin
      result.next_pc <= seq_pc;
    end
  end

  // Delay-slot handling only matters when the branch redirects
  // An untaken branch leaves the following word alone; neither strobe fires
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result.keep_slot   <= 1'b0;
      result.squash_slot <= 1'b0;
    end else begin
      result.keep_slot   <= accept && take && dslot;
      result.squash_slot <= accept && take && !dslot;
    end
  end

  // Cost and mispredict report; cost holds like next_pc
  // Reset shows one cycle so a monitor never reads an undefined cost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result.mispredict <= 1'b0;
      result.cost       <= `CBU_COST_ONE;
    end else begin
      result.mispredict <= accept && wrong;
      if (accept) begin
        result.cost <= next_cost;
      end
    end
  end

  // Flags instructions handed over that this unit does not own
  // Gated by idle like accept, so a dropped word never raises it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      not_branch <= 1'b0;
    end else begin
      not_branch <= issue.valid && !is_branch && (state == cbu_pkg::CBU_IDLE);
    end
  end

endmodule : cbu_branch_unit

// ==== hdl/cbu_pkg.sv ====
// Types shared by the conditional branch unit and its surroundings.
// Assumes cbu_regs.svh is on the include path.
package cbu_pkg;

  // Stall sequencer states
  typedef enum logic [1:0] {
    CBU_IDLE = 2'b00,
    CBU_PEN1 = 2'b01,
    CBU_PEN2 = 2'b10
  } cbu_state_t;

  // Comparison kinds
  typedef enum logic [1:0] {
    CBU_CMP_NONE = 2'b00,
    CBU_CMP_GE   = 2'b01,
    CBU_CMP_GT   = 2'b10,
    CBU_CMP_LE   = 2'b11
  } cbu_cmp_t;

  // Instruction presented by decode
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] program_counter;
    logic [31:0] compare_operand_reg;
    logic [31:0] offset_reg;
    logic        prefix_valid;
    logic [15:0] prefix_hi;
    logic        predict_valid;
    logic        predict_taken;
  } cbu_issue_t;

  // Outcome handed to the PC and fetch stage
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic        pc_load;
    logic [31:0] next_pc;
    logic        keep_slot;
    logic        squash_slot;
    logic        mispredict;
    logic [1:0]  cost;
  } cbu_result_t;

endpackage : cbu_pkg

// ==== hdl/cbu_regs.svh ====
// Constants for the conditional branch unit: field positions, codes, costs.
// Assumes big-endian bit naming in the encoding: position 0 is instr[31].
`ifndef CBU_REGS_SVH
`define CBU_REGS_SVH

// Field positions, expressed as little-endian indices of instr[31:0]
`define CBU_OPC_HI      31
`define CBU_OPC_LO      26
`define CBU_DSLOT_BIT   25
`define CBU_COND_HI     24
`define CBU_COND_LO     21
`define CBU_RA_HI       20
`define CBU_RA_LO       16
`define CBU_RB_HI       15
`define CBU_RB_LO       11
`define CBU_LOW_HI      10
`define CBU_IMM_HI      15

// Major opcodes
`define CBU_OPC_REG     6'h27
`define CBU_OPC_IMM     6'h2f

// Condition codes
`define CBU_COND_GE     4'h5
`define CBU_COND_GT     4'h4
`define CBU_COND_LE     4'h3

// Cycle costs
`define CBU_COST_ONE    2'h1
`define CBU_COST_SLOT   2'h2
`define CBU_COST_FULL   2'h3

// Sequential step and reset values
`define CBU_PC_STEP     32'h00000004
`define CBU_PC_RESET    32'h00000000

`endif

// ==== verification/cbu_branch_unit_tb_top.sv ====
// Self-checking bench for the branch unit.
// Assumes package, design, checker and decode model compiled first.
module cbu_branch_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 busy, not_branch;
  cbu_pkg::cbu_issue_t  issue;
  cbu_pkg::cbu_result_t result;
  int                   fail_count = 0;
  int                   n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  cbu_decode_model dec (.ref_clk(ref_clk), .issue(issue));
  cbu_branch_unit dut (.ref_clk(ref_clk), .resetn(resetn), .issue(issue), .result(result), .busy(busy),
    .not_branch(not_branch));
  // ----------------------------------------
  // Compare and close
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // One branch; pr is prefix, guess valid, guess taken. Expectations from the rules.
  task automatic br(input logic [31:0] ins, ra, rb, input logic [2:0] pr);
    logic        imm, tk;
    logic [31:0] off;
    logic [1:0]  cost;
    imm = ins[31:26] == 6'h2f;
    tk = ins[24:21] == 4'h5 ? !ra[31] : ins[24:21] == 4'h4 ? !ra[31] && ra != 0 : ra[31] || ra == 0;
    off = !imm ? rb : pr[2] ? {16'h5a5a, ins[15:0]} : {{16{ins[15]}}, ins[15:0]};
    cost = imm && pr[1] ? (pr[0] == tk ? 2'h1 : 2'h3) : !tk ? 2'h1 : ins[25] ? 2'h2 : 2'h3;
    dec.send({1'b1, ins, 32'h00004000, ra, rb, pr[2], 16'h5a5a, pr[1:0]});
    check("valid", result.valid, 1'b1);
    check("pc_load", {result.pc_load, not_branch}, 2'h2);
    check("taken", result.taken, tk);
    check("next_pc", result.next_pc, 32'h00004000 + (tk ? off : 32'h4));
    check("slot", {result.keep_slot, result.squash_slot}, {tk && ins[25], tk && !ins[25]});
    check("mispredict", result.mispredict, imm && pr[1] && pr[0] != tk);
    check("cost", result.cost, cost);
    for (int n = 1; n < cost; n++) begin
      check("busy", busy, 1'b1);
      @(negedge ref_clk);
    end
    check("busy end", busy, 1'b0);
  endtask : br
  // Register forms: each condition, sign boundaries, both slot flags, stray guesses
  task automatic t_reg;
    logic [31:0] v [4] = '{32'h0, 32'h1, 32'hffffffff, 32'h80000000};
    for (int c = 3; c < 6; c++)
      for (int i = 0; i < 8; i++)
        br({6'h27, i[0], c[3:0], 10'h022, 11'h000}, v[i >> 1], 32'hfffffff0, i[2:0]);
    $display("register forms done");
  endtask : t_reg
  // Immediate forms: negative offset, prefix, every guess combination, both outcomes
  task automatic t_imm;
    for (int p = 0; p < 16; p++) begin
      br({6'h2f, p[0], 4'h5, 5'h01, 16'h8000}, {p[3], 31'h0}, 32'h0, p[2:0]);
      br({6'h2f, !p[0], 4'h4, 5'h01, 16'h0010}, {31'h0, p[3]}, 32'h0, p[2:0]);
      br({6'h2f, p[0], 4'h3, 5'h01, 16'hfffc}, {31'h0, p[3]}, 32'h0, p[2:0]);
    end
    $display("immediate forms done");
  endtask : t_imm
  // Word offered while a penalty runs must be dropped, not answered
  task automatic t_busy;
    dec.send({1'b1, 6'h27, 1'b0, 4'h5, 10'h022, 11'h000, 32'h00004000, 32'h0, 32'h00000008, 19'h0});
    check("busy", busy, 1'b1);
    dec.send({1'b1, 32'h9c400000, 115'h0});
    check("dropped", {result.valid, not_branch, busy}, 3'h0);
    check("held pc", result.next_pc, 32'h00004008);
    $display("busy drop done");
  endtask : t_busy
  // Words outside this unit: dirty low bits, other condition, other opcode
  task automatic t_foreign;
    logic [31:0] bad [3] = '{32'h9ca21001, 32'h9c400000, 32'h98a00000};
    for (int i = 0; i < 3; i++) begin
      dec.send({1'b1, bad[i], 115'h0});
      check("foreign", {not_branch, result.valid}, 2'h2);
    end
    $display("foreign words done");
  endtask : t_foreign
  // Reset, then the scenarios
  initial begin
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    check("rst pc", result.next_pc, 32'h0);
    check("rst flags", {result.valid, busy, result.cost}, 4'h1);
    t_reg;
    t_imm;
    t_busy;
    t_foreign;
    give_verdict;
  end
endmodule : cbu_branch_unit_tb_top

bind cbu_branch_unit cbu_chk chk (.ref_clk(ref_clk), .resetn(resetn), .issue(issue), .result(result), .busy(busy),
  .not_branch(not_branch));

// ==== verification/cbu_chk_assertions.sv ====
// Checker for the branch unit outcome.
// Assumes a bind onto cbu_branch_unit, one clock domain.
module cbu_chk (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  // Watched ports
  input wire cbu_pkg::cbu_issue_t  issue,
  input wire cbu_pkg::cbu_result_t result,
  input wire logic                 busy,
  input wire logic                 not_branch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Reference decode of the presented word
  // ----------------------------------------
  logic [31:0] ins, ra, off, exp_pc;
  logic        imm, hit, tk, go, dslot;
  assign ins = issue.instr;
  assign ra = issue.compare_operand_reg;
  assign imm = ins[31:26] == 6'h2f;
  assign dslot = ins[25];
  assign hit = (imm || ins[31:26] == 6'h27 && ins[10:0] == 11'h000) && ins[24:21] inside {4'h3, 4'h4, 4'h5};
  assign tk = ins[24:21] == 4'h5 ? !ra[31] : ins[24:21] == 4'h4 ? !ra[31] && ra != 0 : ra[31] || ra == 0;
  assign off = !imm ? issue.offset_reg : issue.prefix_valid ? {issue.prefix_hi, ins[15:0]} : {{16{ins[15]}}, ins[15:0]};
  // Decode is ignored while busy, so only idle cycles start a check
  assign go = issue.valid && !busy;
  assign exp_pc = issue.program_counter + (tk ? off : 32'h00000004);
  a_answer_once: assert property (go && hit |=> result.valid && !not_branch)
    else $error("branch not answered");
  a_foreign_word: assert property (go && !hit |=> not_branch && !result.valid)
    else $error("foreign word answered");
  a_cond_sign: assert property (go && hit |=> result.taken == $past(tk))
    else $error("wrong taken");
  a_target_pc: assert property (go && hit |=> result.next_pc == $past(exp_pc))
    else $error("wrong next pc");
  a_slot_flags: assert property (result.valid |-> result.keep_slot == (result.taken && $past(dslot))
    && result.squash_slot == (result.taken && !$past(dslot))) else $error("wrong slot control");
  a_cost_one: assert property (result.valid && !result.taken && !result.mispredict |-> result.cost == 2'h1 && !busy)
    else $error("untaken not one cycle");
  a_slot_busy: assert property (result.valid && result.cost == 2'h2 |-> busy ##1 !busy)
    else $error("two cycle stall wrong");
  a_full_busy: assert property (result.valid && result.cost == 2'h3 |-> busy [*2] ##1 !busy)
    else $error("three cycle stall wrong");
  a_misp_cost: assert property (result.valid && result.mispredict |-> result.cost == 2'h3)
    else $error("mispredict cost wrong");
  a_pred_hit: assert property (go && hit && imm && issue.predict_valid && issue.predict_taken == tk
    |=> result.cost == 2'h1 && !result.mispredict) else $error("good guess stalled");
  a_load_strobe: assert property (result.pc_load == result.valid)
    else $error("pc load strobe wrong");
  a_busy_drop: assert property (issue.valid && busy |=> !result.valid && !not_branch)
    else $error("word taken while busy");
endmodule : cbu_chk

// ==== verification/cbu_decode_model.sv ====
// Decode stage model: presents one word per call.
// Assumes the bench waits out busy before the next call.
module cbu_decode_model (
  // Clock
  input wire logic            ref_clk,
  // Issue to the unit
  output cbu_pkg::cbu_issue_t issue
);
  timeunit 1ns;
  timeprecision 1ps;
  initial issue = '0;
  // Word stands one cycle; idle lines then show its inverse, never the old word
  task automatic send(input cbu_pkg::cbu_issue_t w);
    cbu_pkg::cbu_issue_t idle;
    idle = ~w;
    idle.valid = 1'b0;
    @(negedge ref_clk);
    issue = w;
    @(negedge ref_clk);
    issue = idle;
  endtask : send
endmodule : cbu_decode_model
